/* rtl/ssm_pkg.sv */
// socket status mask and live state: shared constants and carrier types
// assumes one core clock; all pins arrive already synchronous to it
package ssm_pkg;

    // ========================================================
    // register offsets from the socket base address
    localparam logic [7:0]  SSM_MASK_OFS   = 8'h04;
    localparam logic [7:0]  SSM_STATE_OFS  = 8'h08;

    // ========================================================
    // mask register field positions
    localparam int          SSM_PWR_BIT    = 3;
    localparam int          SSM_CD_HI      = 2;
    localparam int          SSM_CD_LO      = 1;
    localparam int          SSM_CS_BIT     = 0;
    localparam logic [1:0]  SSM_CD_ON      = 2'h3;

    // ========================================================
    // live state register field positions
    localparam int          SSM_YV_SOCK    = 31;
    localparam int          SSM_XV_SOCK    = 30;
    localparam int          SSM_3V_SOCK    = 29;
    localparam int          SSM_5V_SOCK    = 28;
    localparam int          SSM_ZV_BIT     = 27;
    localparam int          SSM_CARDV_HI   = 13;
    localparam int          SSM_CARDV_LO   = 10;
    localparam int          SSM_CD2_BIT    = 2;
    localparam int          SSM_CD1_BIT    = 1;
    localparam int          SSM_CSL_BIT    = 0;

    // ========================================================
    // reset values
    localparam logic [3:0]  SSM_MASK_RST   = 4'h0;
    localparam logic [3:0]  SSM_EVENT_RST  = 4'h0;
    localparam logic [2:0]  SSM_SOCKV_RST  = 3'h1;
    localparam logic        SSM_ZV_RST     = 1'b0;
    localparam logic [3:0]  SSM_CARDV_RST  = 4'h0;
    localparam logic [31:0] SSM_ZERO_WORD  = 32'h0000_0000;

    // ========================================================
    // carrier types
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ssm_req_t;

    typedef struct packed {
        logic socket_powered_flag;
        logic card_detect_two_level;
        logic card_detect_one_level;
        logic card_status_line_level;
    } ssm_pins_t;

    typedef struct packed {
        logic       inserted;
        logic       is_cardbus;
        logic [3:0] volt;
    } ssm_card_t;

    typedef struct packed {
        logic        wr;
        logic [31:0] data;
    } ssm_force_t;

endpackage : ssm_pkg

/* rtl/ssm_socket_status.sv */
// socket interrupt mask and live socket state registers with event flags
// assumes pins, force writes and card interrogation come from neighbours
// in the same clock domain; register reads answer one cycle later
//
// Overview of operation
// - event flags set regardless of mask
// - mask bit 3 gates power-cycle interrupt
// - card detect field 11 enables, others block
// - mask bit 0 gates status line interrupt
// - unused mask and state bits read zero
// - mask cleared by global, or bus reset while PME is disabled
// - force writes show in live state
// - card voltage fields load at insertion, force writes OR in bits
// - detect pins frozen during card interrogation
// - bits 31,30 zero unless forced
// - bit 29 one unless forced
// - bit 28 one unless control override
// - bit 27 follows forced zoomed video value
// - card voltage bits settable by force write
// - any enabled set flag raises interrupt
// - status event rising cardbus, both 16-bit
// - bits 2..0 mirror detect and status pins
`timescale 1ns/1ps
`default_nettype none

module ssm_socket_status (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              ce_in,
    input  wire logic              global_reset_pin_in,
    input  wire logic              bus_reset_pin_in,
    input  wire logic              pme_enable_in,
    input  wire ssm_pkg::ssm_req_t reg_req_in,
    output logic [31:0]            reg_rdata_out,
    input  wire ssm_pkg::ssm_pins_t pins_in,
    input  wire logic              interrogating_in,
    input  wire ssm_pkg::ssm_card_t card_in,
    input  wire ssm_pkg::ssm_force_t force_in,
    input  wire logic              five_volt_override_in,
    input  wire logic [3:0]        event_clear_in,
    output logic [3:0]             event_flags_out,
    output logic                   status_change_irq_out
);
    import ssm_pkg::*;

    // ========================================================
    // state
    logic [3:0]  mask_q;
    logic [3:0]  event_q;
    logic [3:0]  event_set;
    logic [2:0]  sockv_q;
    logic        zv_q;
    logic [3:0]  cardv_q;
    logic        cd1_q;
    logic        cd2_q;
    logic        powered_q;
    logic        csl_q;
    logic        cd_en;
    logic        ctx_clear;
    logic        mask_wr;
    logic [31:0] state_word;
    logic [31:0] rdata_q;

    // context bits survive a bus reset while wake events are enabled
    assign ctx_clear = srst_in | global_reset_pin_in
                     | (bus_reset_pin_in & ~pme_enable_in);
    assign mask_wr   = reg_req_in.sel & reg_req_in.wr
                     & (reg_req_in.addr == SSM_MASK_OFS);

    // ========================================================
    // interrupt mask register
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            mask_q <= SSM_MASK_RST;
        end
        else if (ce_in && mask_wr)
        begin
            mask_q <= reg_req_in.wdata[3:0];
        end
    end

    // ========================================================
    // reported detect pins, held while the card is interrogated
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            cd1_q <= 1'b1;
            cd2_q <= 1'b1;
        end
        else if (ce_in && !interrogating_in)
        begin
            cd1_q <= pins_in.card_detect_one_level;
            cd2_q <= pins_in.card_detect_two_level;
        end
    end

    // previous levels of the power and status line for change detection
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            powered_q <= 1'b0;
            csl_q     <= 1'b0;
        end
        else if (ce_in)
        begin
            powered_q <= pins_in.socket_powered_flag;
            csl_q     <= pins_in.card_status_line_level;
        end
    end

    // ========================================================
    // event detection, independent of the mask
    always_comb
    begin
        event_set[SSM_PWR_BIT] = pins_in.socket_powered_flag ^ powered_q;
        event_set[SSM_CD_HI]   = ~interrogating_in
                               & (pins_in.card_detect_two_level ^ cd2_q);
        event_set[SSM_CD_LO]   = ~interrogating_in
                               & (pins_in.card_detect_one_level ^ cd1_q);
        if (card_in.is_cardbus)
        begin
            event_set[SSM_CS_BIT] = pins_in.card_status_line_level & ~csl_q;
        end
        else
        begin
            event_set[SSM_CS_BIT] = pins_in.card_status_line_level ^ csl_q;
        end
        if (force_in.wr)
        begin
            event_set = event_set | force_in.data[3:0];
        end
    end

    // sticky event flags; a set in the clearing cycle wins
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            event_q <= SSM_EVENT_RST;
        end
        else if (ce_in)
        begin
            event_q <= (event_q & ~event_clear_in) | event_set;
        end
    end

    // ========================================================
    // socket capability and zoomed video, written by force writes
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            sockv_q <= SSM_SOCKV_RST;
            zv_q    <= SSM_ZV_RST;
        end
        else if (ce_in && force_in.wr)
        begin
            sockv_q <= force_in.data[SSM_YV_SOCK:SSM_3V_SOCK];
            zv_q    <= force_in.data[SSM_ZV_BIT];
        end
    end

    // card voltage support, captured at insertion or set by force writes
    always_ff @(posedge core_clk_in)
    begin
        if (ctx_clear)
        begin
            cardv_q <= SSM_CARDV_RST;
        end
        else if (ce_in && card_in.inserted)
        begin
            cardv_q <= card_in.volt;
        end
        else if (ce_in && force_in.wr)
        begin
            cardv_q <= cardv_q | force_in.data[SSM_CARDV_HI:SSM_CARDV_LO];
        end
    end

    // ========================================================
    // live state word; unlisted bits read as zero
    always_comb
    begin
        state_word = SSM_ZERO_WORD;
        state_word[SSM_YV_SOCK:SSM_3V_SOCK] = sockv_q;
        state_word[SSM_5V_SOCK] = ~five_volt_override_in;
        state_word[SSM_ZV_BIT]  = zv_q;
        state_word[SSM_CARDV_HI:SSM_CARDV_LO] = cardv_q;
        state_word[SSM_CD2_BIT] = cd2_q;
        state_word[SSM_CD1_BIT] = cd1_q;
        state_word[SSM_CSL_BIT] = pins_in.card_status_line_level;
    end

    // read data registered; unmapped offsets answer zero
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            rdata_q <= SSM_ZERO_WORD;
        end
        else if (ce_in && reg_req_in.sel && !reg_req_in.wr)
        begin
            if (reg_req_in.addr == SSM_MASK_OFS)
            begin
                rdata_q <= {28'h000_0000, mask_q};
            end
            else if (reg_req_in.addr == SSM_STATE_OFS)
            begin
                rdata_q <= state_word;
            end
            else
            begin
                rdata_q <= SSM_ZERO_WORD;
            end
        end
    end

    // ========================================================
    // interrupt: reserved detect codes 01 and 10 block like 00
    assign cd_en = (mask_q[SSM_CD_HI:SSM_CD_LO] == SSM_CD_ON);
    assign status_change_irq_out =
          (event_q[SSM_PWR_BIT] & mask_q[SSM_PWR_BIT])
        | (event_q[SSM_CD_HI]   & cd_en)
        | (event_q[SSM_CD_LO]   & cd_en)
        | (event_q[SSM_CS_BIT]  & mask_q[SSM_CS_BIT]);
    assign event_flags_out = event_q;
    assign reg_rdata_out   = rdata_q;

    // ========================================================
    // assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    property p_mask_write;
        ce_in && mask_wr && !ctx_clear |=> mask_q == $past(reg_req_in.wdata[3:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_pwr_irq;
        event_q[SSM_PWR_BIT] && mask_q[SSM_PWR_BIT] |-> status_change_irq_out;
    endproperty
    a_pwr_irq: assert property (p_pwr_irq) else $error("power irq missing");

    property p_cd_block;
        mask_q[SSM_CD_HI] != mask_q[SSM_CD_LO] && !mask_q[SSM_PWR_BIT]
            && !mask_q[SSM_CS_BIT] |-> !status_change_irq_out;
    endproperty
    a_cd_block: assert property (p_cd_block) else $error("reserved cd code fired");

    property p_cs_gate;
        !mask_q[SSM_CS_BIT] && !mask_q[SSM_PWR_BIT] && !cd_en
            |-> !status_change_irq_out;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("masked irq fired");

    property p_cb_rise;
        ce_in && !ctx_clear && card_in.is_cardbus && !csl_q
            && pins_in.card_status_line_level |=> event_q[SSM_CS_BIT];
    endproperty
    a_cb_rise: assert property (p_cb_rise) else $error("rise not flagged");

    property p_16_fall;
        ce_in && !ctx_clear && !card_in.is_cardbus && csl_q
            && !pins_in.card_status_line_level |=> event_q[SSM_CS_BIT];
    endproperty
    a_16_fall: assert property (p_16_fall) else $error("fall not flagged");

    property p_rsvd_read;
        ce_in && reg_req_in.sel && !reg_req_in.wr && reg_req_in.addr == SSM_STATE_OFS
            |=> reg_rdata_out[26:14] == 13'h0000 && reg_rdata_out[SSM_5V_SOCK]
                == !$past(five_volt_override_in);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("state read bad");

    property p_cardv_hold;
        !ctx_clear && !(ce_in && (card_in.inserted || force_in.wr)) |=> $stable(cardv_q);
    endproperty
    a_cardv_hold: assert property (p_cardv_hold) else $error("card volts moved");

    property p_cd_freeze;
        interrogating_in && !ctx_clear |=> $stable(cd1_q) && $stable(cd2_q);
    endproperty
    a_cd_freeze: assert property (p_cd_freeze) else $error("cd changed in interrogation");

    property p_pme_keep;
        bus_reset_pin_in && pme_enable_in && !global_reset_pin_in
            && !(ce_in && mask_wr) |=> $stable(mask_q);
    endproperty
    a_pme_keep: assert property (p_pme_keep) else $error("mask lost on bus reset");

    c_irq_cd: cover property (cd_en && event_q[SSM_CD_LO] ##1 status_change_irq_out);
    c_force_zv: cover property (ce_in && force_in.wr ##1 zv_q);
    c_insert: cover property (ce_in && card_in.inserted ##1 cardv_q != SSM_CARDV_RST);

endmodule : ssm_socket_status

`default_nettype wire

/* dv/ssm_card_model.sv */
// card in the socket: detect pins, status line, insertion details
// assumes the bench commands it in step with the core clock
`timescale 1ns/1ps
`default_nettype none

module ssm_card_model (
    input  wire logic          core_clk_in,
    input  wire logic          present_in,
    input  wire logic          cardbus_in,
    input  wire logic          stat_in,
    input  wire logic          powered_in,
    input  wire logic [3:0]    volt_in,
    output ssm_pkg::ssm_pins_t pins_out,
    output ssm_pkg::ssm_card_t card_out
);
    import ssm_pkg::*;

    logic present_q = 1'b0;

    // ============================================================
    // detect pins pulled high when empty; one insertion pulse per card
    always_ff @(posedge core_clk_in)
    begin
        present_q <= present_in;
        pins_out  <= '{powered_in, !present_in, !present_in, stat_in};
        card_out  <= '{present_in & !present_q, cardbus_in, volt_in};
    end
endmodule : ssm_card_model

`default_nettype wire

/* dv/ssm_socket_status_bench.sv */
// self-checking bench for the socket mask and live state registers
// assumes the card model drives pins; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none

module ssm_socket_status_bench;
    import ssm_pkg::*;

    logic        clk = 0, srst = 1, global_reset_pin = 0, brst = 0, pme = 0;
    logic        intg = 0, ovr = 0, pres = 0, cb = 1, stat = 0, pwr = 0, ce = 1;
    logic [3:0]  volt = 4'h0, clr = 4'h0, flags;
    logic [31:0] rdata;
    logic        irq;
    ssm_req_t    req = '0;
    ssm_force_t  frc = '0;
    ssm_pins_t   pins;
    ssm_card_t   card;
    int          miscompares = 0, check_count = 0, cyc_n = 0;

    // ============================================================
    // design and card
    ssm_socket_status i_dut (.core_clk_in(clk), .srst_in(srst),
        .ce_in(ce), .global_reset_pin_in(global_reset_pin), .bus_reset_pin_in(brst),
        .pme_enable_in(pme), .reg_req_in(req), .reg_rdata_out(rdata),
        .pins_in(pins), .interrogating_in(intg), .card_in(card),
        .force_in(frc), .five_volt_override_in(ovr), .event_clear_in(clr),
        .event_flags_out(flags), .status_change_irq_out(irq));
    ssm_card_model i_card (.core_clk_in(clk), .present_in(pres),
        .cardbus_in(cb), .stat_in(stat), .powered_in(pwr),
        .volt_in(volt), .pins_out(pins), .card_out(card));

    // ============================================================
    // clock and hang guard
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            miscompares++;
            results();
        end
    end

    // ============================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, 32'h0000_0000};
        @(negedge clk);
        req.sel = 1'b0;
        chk($sformatf("reg %h", a), e, rdata);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{1'b1, 1'b1, a, d};
        @(negedge clk);
        req.sel = 1'b0;
    endtask : wr
    task automatic ev(input logic [4:0] e);
        cyc(3);
        chk("irq_flags", {27'h0, e}, {27'h0, irq, flags});
    endtask : ev
    task automatic clrev();
        clr = 4'hF;
        @(negedge clk);
        clr = 4'h0;
    endtask : clrev
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // ============================================================
    // test sequence
    initial
    begin
        cyc(8);
        srst = 0;
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h3000_0006);
        ev(5'h00);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0000_000F);
        wr(8'h08, 32'h0000_0000);
        rd(8'h08, 32'h3000_0006);
        rd(8'h10, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        $display("test registers done");
        pwr = 1;
        ev(5'h08);
        wr(8'h04, 32'h0000_0007);
        ev(5'h08);
        wr(8'h04, 32'h0000_0008);
        ev(5'h18);
        clrev();
        ev(5'h00);
        $display("test power done");
        volt = 4'h5;
        pres = 1;
        ev(5'h06);
        rd(8'h08, 32'h3000_1400);
        wr(8'h04, 32'h0000_0002);
        ev(5'h06);
        wr(8'h04, 32'h0000_0004);
        ev(5'h06);
        wr(8'h04, 32'h0000_0006);
        ev(5'h16);
        volt = 4'hA;
        rd(8'h08, 32'h3000_1400);
        clrev();
        intg = 1;
        pres = 0;
        ev(5'h00);
        rd(8'h08, 32'h3000_1400);
        intg = 0;
        ev(5'h16);
        rd(8'h08, 32'h3000_1406);
        clrev();
        $display("test detect done");
        wr(8'h04, 32'h0000_0001);
        stat = 1;
        ev(5'h11);
        rd(8'h08, 32'h3000_1407);
        clrev();
        stat = 0;
        ev(5'h00);
        cb = 0;
        cyc(2);
        stat = 1;
        ev(5'h11);
        clrev();
        stat = 0;
        ev(5'h11);
        wr(8'h04, 32'h0000_0000);
        ev(5'h01);
        clrev();
        $display("test status line done");
        frc = '{1'b1, 32'hE800_0C01};
        @(negedge clk);
        frc.wr = 0;
        ovr = 1;
        rd(8'h08, 32'hE800_1C06);
        ev(5'h01);
        frc = '{1'b1, 32'h0000_0000};
        @(negedge clk);
        frc.wr = 0;
        ovr = 0;
        rd(8'h08, 32'h1000_1C06);
        $display("test force done");
        wr(8'h04, 32'h0000_000F);
        pme = 1;
        brst = 1;
        @(negedge clk);
        brst = 0;
        rd(8'h04, 32'h0000_000F);
        ev(5'h11);
        pme = 0;
        brst = 1;
        @(negedge clk);
        brst = 0;
        rd(8'h04, 32'h0000_0000);
        // powered pin is still high against its cleared history: flag sets again
        ev(5'h08);
        wr(8'h04, 32'h0000_000F);
        pme = 1;
        global_reset_pin = 1;
        @(negedge clk);
        global_reset_pin = 0;
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h3000_0006);
        // a write while the clock enable is low must not land
        ce = 0;
        wr(8'h04, 32'h0000_000F);
        ce = 1;
        rd(8'h04, 32'h0000_0000);
        $display("test resets done");
        results();
    end
endmodule : ssm_socket_status_bench

`default_nettype wire
